// [hdl/ddr2_mode_map.svh]
// field positions, codes and timing counts of the mode register block
// assumes inclusion by bare name from the design files
`ifndef DDR2_MODE_MAP_SVH
`define DDR2_MODE_MAP_SVH
// wishbone byte offsets
`define OFS_MODE_CMD 4'h0
`define OFS_MAIN_MODE 4'h4
`define OFS_EXT_MODE 4'h8
`define OFS_STATUS 4'hC
// main mode register fields
`define BL_LSB 0
`define BL_MSB 2
`define BT_BIT 3
`define CL_LSB 4
`define CL_MSB 6
`define TM_BIT 7
`define DLLRST_BIT 8
`define WR_LSB 9
`define WR_MSB 11
`define PD_BIT 12
// extended mode register fields
`define DLLDIS_BIT 0
`define AL_LSB 3
`define AL_MSB 5
// field codes
`define BL_CODE4 3'h2
`define BL_CODE8 3'h3
// reset values
`define MAIN_RESET 13'h0000
`define EXT_RESET 13'h0000
// dll lock wait, 200 clocks
`define DLL_LOCK_CYCLES 8'hC8
`endif

// [hdl/ddr2_mode_pkg.sv]
// types of the mode register block
// assumes the map header for numbers
package ddr2_mode_pkg;
  typedef enum logic [1:0] {DLL_OFF, DLL_LOCKING, DLL_LOCKED} dll_state_type;
  typedef struct packed {
    logic [2:0] beat;
    logic [2:0] start;
    logic eight;
    logic inter;
  } order_type;
endpackage

// [hdl/burst_order.sv]
// burst column order generator
// assumes start column and mode held steady during a burst
`timescale 1ns/1ps
`default_nettype none
module burst_order (
  // burst setup
  input wire logic [2:0] startCol,
  input wire logic eightBeat,
  input wire logic interleaved,
  input wire logic [2:0] beat,
  // column low bits
  output logic [2:0] colLow
);
  logic [2:0] seqCol;
  logic [2:0] intCol;
  always_comb begin
    seqCol = 3'(startCol + beat);
    intCol = startCol ^ beat;
    if (eightBeat) begin
      colLow = interleaved ? intCol : seqCol;
    end else begin
      colLow = {startCol[2], interleaved ? intCol[1:0] : seqCol[1:0]};
    end
  end
endmodule // burst_order
`default_nettype wire

// [hdl/ddr2_mode_register_decode.sv]
// mode and extended mode registers with burst, latency and dll control
// assumes load-mode commands only with all banks idle
//
// Chosen here: the address map and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_mode_map.svh"
module ddr2_mode_register_decode
  import ddr2_mode_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [3:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  // memory commands
  input wire logic readCmd,
  input wire logic writeApCmd,
  input wire logic [2:0] startCol,
  input wire logic selfRefreshEnter,
  input wire logic selfRefreshExit,
  input wire logic activePowerDown,
  // burst and timing outputs
  output logic [2:0] colLow,
  output logic burstActive,
  output logic readData,
  output logic precharge,
  output logic dllReset,
  output logic dllLocked,
  output logic dllFrozen
);
  typedef struct packed {
    logic [12:0] mainMode;
    logic [12:0] extMode;
    logic [31:0] rdat;
    logic ack;
    dll_state_type dll;
    logic [7:0] lockCnt;
    logic dllRst;
    logic [15:0] readPipe;
    logic [3:0] wrBurstCnt;
    logic [2:0] wrRecCnt;
    logic wrRecRun;
    logic prech;
    logic [2:0] beat;
    logic [2:0] start;
    logic burstRun;
    logic [3:0] beatsLeft;
    logic selfRef;
  } state_type;
  state_type s_q, s_d;
  logic [2:0] blCode;
  logic eightBeat;
  logic [3:0] clVal;
  logic [3:0] alVal;
  logic [4:0] rlVal;
  logic [3:0] wrVal;
  logic [3:0] burstBeats;
  logic wbReq;
  logic [15:0] wMask;
  logic [12:0] loadVal;

  burst_order u_order (
    .startCol(s_q.start),
    .eightBeat(eightBeat),
    .interleaved(s_q.mainMode[`BT_BIT]),
    .beat(s_q.beat),
    .colLow(colLow)
  );

  always_comb begin
    blCode = s_q.mainMode[`BL_MSB:`BL_LSB];
    eightBeat = (blCode == `BL_CODE8);
    burstBeats = eightBeat ? 4'h8 : 4'h4;
    clVal = {1'b0, s_q.mainMode[`CL_MSB:`CL_LSB]};
    alVal = {1'b0, s_q.extMode[`AL_MSB:`AL_LSB]};
    rlVal = 5'(clVal + alVal);
    wrVal = 4'(s_q.mainMode[`WR_MSB:`WR_LSB] + 3'h1);
    wbReq = wbCyc && wbStb && !s_q.ack;
    wMask = {{8{wbSel[1]}}, {8{wbSel[0]}}};
    loadVal = 13'((wbDatI[15:0] & wMask) | ({3'h0, s_q.mainMode} & ~wMask));
  end

  always_comb begin
    s_d = s_q;
    s_d.ack = wbReq;
    s_d.dllRst = 1'b0;
    s_d.prech = 1'b0;
    s_d.mainMode[`DLLRST_BIT] = 1'b0;
    case (wbAdr)
      `OFS_MAIN_MODE: s_d.rdat = {19'h0, s_q.mainMode};
      `OFS_EXT_MODE: s_d.rdat = {19'h0, s_q.extMode};
      `OFS_STATUS: s_d.rdat = {27'h0, s_q.selfRef, s_q.dll == DLL_LOCKED, rlVal[2:0]};
      default: s_d.rdat = 32'h0000_0000;
    endcase
    if (wbReq && wbWe && wbAdr == `OFS_MODE_CMD) begin
      if (wbDatI[17:16] == 2'h0) begin
        if (!wbDatI[`TM_BIT]) begin
          s_d.mainMode = loadVal;
          s_d.mainMode[`DLLRST_BIT] = 1'b0;
          if (wbDatI[`DLLRST_BIT]) begin
            s_d.dllRst = 1'b1;
          end
        end
      end else if (wbDatI[17:16] == 2'h1) begin
        s_d.extMode = wbDatI[12:0];
      end
    end
    case (s_q.dll)
      DLL_LOCKING: begin
        if (s_q.lockCnt == 8'h01) begin
          s_d.dll = DLL_LOCKED;
        end
        s_d.lockCnt = 8'(s_q.lockCnt - 8'h01);
      end
      DLL_OFF: ;
      DLL_LOCKED: ;
      default: s_d.dll = DLL_OFF;
    endcase
    // dll enable and reset
    // disable and restart override the running lock count
    if (s_q.extMode[`DLLDIS_BIT] || s_q.selfRef) begin
      s_d.dll = DLL_OFF;
    end else if (s_q.dllRst) begin
      s_d.dll = DLL_LOCKING;
      s_d.lockCnt = `DLL_LOCK_CYCLES;
    end
    if (selfRefreshEnter) begin
      s_d.selfRef = 1'b1;
    end else if (selfRefreshExit && s_q.selfRef) begin
      s_d.selfRef = 1'b0;
      s_d.dllRst = 1'b1;
    end
    s_d.readPipe = {1'b0, s_q.readPipe[15:1]};
    if (readCmd && rlVal != 5'h00) begin
      s_d.readPipe[rlVal[3:0] - 4'h1] = 1'b1;
    end
    if (s_q.burstRun) begin
      s_d.beat = 3'(s_q.beat + 3'h1);
      s_d.beatsLeft = 4'(s_q.beatsLeft - 4'h1);
      s_d.burstRun = s_q.beatsLeft != 4'h1;
    end
    if (readCmd || writeApCmd) begin
      s_d.start = startCol;
      s_d.beat = 3'h0;
      s_d.burstRun = 1'b1;
      s_d.beatsLeft = burstBeats;
    end
    if (writeApCmd) begin
      // write latency plus half the beats, one count taken by the registered pulse
      s_d.wrBurstCnt = 4'(rlVal[3:0] - 4'h2 + (burstBeats >> 1));
      s_d.wrRecRun = 1'b1;
      s_d.wrRecCnt = wrVal[2:0];
    end else if (s_q.wrRecRun) begin
      if (s_q.wrBurstCnt != 4'h0) begin
        s_d.wrBurstCnt = 4'(s_q.wrBurstCnt - 4'h1);
      end else if (s_q.wrRecCnt != 3'h1) begin
        s_d.wrRecCnt = 3'(s_q.wrRecCnt - 3'h1);
      end else begin
        s_d.wrRecRun = 1'b0;
        s_d.prech = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_q <= '0;
      s_q.mainMode <= `MAIN_RESET;
      s_q.extMode <= `EXT_RESET;
      s_q.dll <= DLL_OFF;
    end else begin
      s_q <= s_d;
    end
  end

  assign wbAck = s_q.ack;
  assign wbDatO = s_q.rdat;
  assign burstActive = s_q.burstRun;
  assign readData = s_q.readPipe[0];
  assign precharge = s_q.prech;
  assign dllReset = s_q.dllRst;
  assign dllLocked = s_q.dll == DLL_LOCKED;
  assign dllFrozen = activePowerDown && s_q.mainMode[`PD_BIT];
endmodule // ddr2_mode_register_decode
`default_nettype wire

// [sim/ddr2_mode_register_decode_asserts.sv]
// port timing checker of the mode block
// assumes a bind from the bench top
`timescale 1ns/1ps
`default_nettype none
module ddr2_mode_register_decode_asserts (
  // observed ports
  input wire logic clk,
  input wire logic rstn,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbAck,
  input wire logic readCmd,
  input wire logic readData,
  input wire logic burstActive,
  input wire logic selfRefreshEnter,
  input wire logic activePowerDown,
  input wire logic dllReset,
  input wire logic dllLocked,
  input wire logic dllFrozen
);
  logic [7:0] age_q;
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) age_q <= 8'h00;
    else age_q <= dllReset ? 8'h00 : age_q + {7'h00, age_q != 8'hFF};
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_ack_next: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
    else $error("ack late");
  chk_ack_drop: assert property (wbAck |=> !wbAck)
    else $error("ack held");
  chk_lock_early: assert property ($rose(dllLocked) |-> age_q >= 8'hC6)
    else $error("lock early");
  chk_read_min: assert property (readCmd |=> !readData ##1 !readData)
    else $error("data early");
  chk_read_max: assert property (readCmd |-> ##[3:10] readData)
    else $error("data missing");
  chk_burst_min: assert property ($rose(burstActive) |-> burstActive[*4])
    else $error("burst short");
  chk_burst_max: assert property ($rose(burstActive) |-> ##[4:8] !burstActive)
    else $error("burst long");
  chk_dllrst_pulse: assert property (dllReset |=> !dllReset)
    else $error("dll reset held");
  chk_frozen_pd: assert property (dllFrozen |-> activePowerDown)
    else $error("frozen idle");
  chk_srf_off: assert property (selfRefreshEnter |-> ##[1:3] !dllLocked)
    else $error("dll on");
endmodule // ddr2_mode_register_decode_asserts
`default_nettype wire

// [sim/ddr2_ctrl_model.sv]
// controller model issuing read and write commands
// assumes calls of issue right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module ddr2_ctrl_model (
  // clock, reset, dll
  input wire logic clk,
  input wire logic rstn,
  input wire logic dllReset,
  // commands
  output logic readCmd,
  output logic writeApCmd,
  output logic [2:0] startCol
);
  int holdOff = 0;
  initial {readCmd, writeApCmd, startCol} = 5'h00;
  always @(posedge clk) holdOff <= !rstn || dllReset ? 200 : holdOff - (holdOff > 0);
  task automatic issue(input logic ap, input logic [2:0] s);
    for (int i = 0; i < 300 && holdOff != 0; i++) @(posedge clk);
    {readCmd, writeApCmd, startCol} <= {!ap, ap, s};
    @(posedge clk);
    {readCmd, writeApCmd, startCol} <= {2'b00, ~s};
  endtask
endmodule // ddr2_ctrl_model
`default_nettype wire

// [sim/ddr2_mode_register_decode_bench.sv]
// bench of the mode block over wishbone and the command model
// assumes package, header, checker and model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ddr2_mode_map.svh"
module ddr2_mode_register_decode_bench;
  logic clk = 0, rstn = 0, wbCyc = 0, wbStb = 0, wbWe = 0, activePowerDown = 0;
  logic selfRefreshEnter = 0, selfRefreshExit = 0, wbAck, readCmd, writeApCmd, readData;
  logic precharge, dllReset, dllLocked, dllFrozen, burstActive;
  logic [3:0] wbAdr = 4'h0, wbSel = 4'hF;
  logic [31:0] wbDatI = 32'h0, wbDatO, rd;
  logic [2:0] startCol, colLow;
  logic [2:0] beats[$];
  int failures = 0, samples_checked = 0;
  wire [3:0] sigs = {dllLocked, precharge, readData, wbAck};
  always #5 clk = ~clk;
  always @(posedge clk) if (burstActive === 1'b1) beats.push_back(colLow);
  ddr2_mode_register_decode dut_u (
    .clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
    .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .readCmd(readCmd),
    .writeApCmd(writeApCmd), .startCol(startCol), .selfRefreshEnter(selfRefreshEnter),
    .selfRefreshExit(selfRefreshExit), .activePowerDown(activePowerDown), .colLow(colLow),
    .burstActive(burstActive), .readData(readData), .precharge(precharge),
    .dllReset(dllReset), .dllLocked(dllLocked), .dllFrozen(dllFrozen)
  );
  ddr2_ctrl_model ctrl_u (
    .clk(clk), .rstn(rstn), .dllReset(dllReset), .readCmd(readCmd),
    .writeApCmd(writeApCmd), .startCol(startCol)
  );
  task automatic test_done;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitSig(input int w, output int n);
    n = 0;
    do begin @(posedge clk); n++; end while (sigs[w] !== 1'b1 && n < 300);
    if (n >= 300) begin
      check(0, 1);
      test_done();
    end
  endtask
  task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'b11, w, a, d};
    waitSig(0, n);
    rd = wbDatO;
    {wbCyc, wbStb} <= 2'b00;
  endtask
  initial begin
    int n;
    repeat (12) @(posedge clk);
    rstn <= 1;
    wb(`OFS_MAIN_MODE, 0, 0); check(rd, 32'h0);
    wb(4'h2, 0, 0); check(rd, 32'h0);
    wb(`OFS_MODE_CMD, 1, 32'h1_0010); wb(`OFS_EXT_MODE, 0, 0); check(rd, 32'h10);
    wb(`OFS_MODE_CMD, 1, 32'h533); wb(`OFS_MAIN_MODE, 0, 0); check(rd, 32'h433);
    waitSig(3, n); check(n >= 190, 1);
    wb(`OFS_STATUS, 0, 0); check(rd, 32'hD);
    wb(`OFS_MODE_CMD, 1, 32'hFF); wb(`OFS_MAIN_MODE, 1, 0);
    wb(`OFS_MAIN_MODE, 0, 0); check(rd, 32'h433);
    $display("register test done");
    for (int k = 0; k < 4; k++) begin
      wb(`OFS_MODE_CMD, 1, {19'h0, 6'h08, 3'h3, k[1], k[0] ? `BL_CODE8 : `BL_CODE4});
      beats = {};
      ctrl_u.issue(0, 3'h5); waitSig(1, n); check(n, 5);
      repeat (6) @(posedge clk);
      check(beats.size(), k[0] ? 8 : 4);
      foreach (beats[i]) check(beats[i], k[0] ? (k[1] ? 5 ^ i : (5 + i) % 8)
        : {1'b1, k[1] ? 2'(1 ^ i) : 2'(1 + i)});
    end
    $display("burst test done");
    ctrl_u.issue(1, 3'h0); waitSig(2, n); check(n, 11);
    wb(`OFS_MODE_CMD, 1, 32'h1433); activePowerDown <= 1; repeat (2) @(posedge clk);
    check(dllFrozen, 1);
    wb(`OFS_MODE_CMD, 1, 32'h433); @(posedge clk); check(dllFrozen, 0);
    activePowerDown <= 0;
    selfRefreshEnter <= 1; @(posedge clk); selfRefreshEnter <= 0; repeat (4) @(posedge clk);
    check(dllLocked, 0);
    selfRefreshExit <= 1; @(posedge clk); selfRefreshExit <= 0;
    waitSig(3, n); check(n >= 190, 1);
    $display("power test done");
    test_done();
  end
endmodule // ddr2_mode_register_decode_bench
bind ddr2_mode_register_decode ddr2_mode_register_decode_asserts chk_u (
  .clk(clk), .rstn(rstn), .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .readCmd(readCmd),
  .readData(readData), .burstActive(burstActive), .selfRefreshEnter(selfRefreshEnter),
  .activePowerDown(activePowerDown), .dllReset(dllReset), .dllLocked(dllLocked),
  .dllFrozen(dllFrozen)
);
`default_nettype wire
